// File: hw/miwa_pkg.sv
package miwa_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // Register offsets in the microcontroller memory space
  localparam logic [15:0] INT0_FLAG_ADDR = 16'h7F00;
  localparam logic [15:0] INT0_ENABLE_MASK_ADDR = 16'h7F01;
  localparam logic [15:0] INT1_FLAG_ADDR = 16'h7F02;
  localparam logic [15:0] INT1_ENABLE_MASK_ADDR = 16'h7F03;
  localparam logic [15:0] WAKE_FLAG_GROUP1_ADDR = 16'h7F2A;

  // Reset values
  localparam logic [7:0] INT0_FLAG_RST = 8'h00;
  localparam logic [7:0] INT0_ENABLE_MASK_RST = 8'h00;
  localparam logic [7:0] INT1_FLAG_RST = 8'h00;
  localparam logic [7:0] INT1_ENABLE_MASK_RST = 8'h00;
  localparam logic [7:0] WAKE_FLAG_GROUP1_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VAL = 8'h00;

  // Interrupt-0 group bit positions
  localparam int INT0_PORT_D_BIT = 7;
  localparam int INT0_PORT_C_BIT = 6;
  localparam int INT0_PORT_B_BIT = 5;
  localparam int INT0_PORT_A_BIT = 4;
  localparam int INT0_SERIAL_BUS2_BIT = 3;
  localparam int INT0_EE_WAKE_4_BIT = 2;
  localparam int INT0_EE_WAKE_2_BIT = 1;
  localparam int INT0_EE_WAKE_3_BIT = 0;

  // Interrupt-1 group bit positions
  localparam int INT1_KBD_FULL_BIT = 7;
  localparam int INT1_KEY_MATRIX_BIT = 6;
  localparam int INT1_EC_INPUT_BIT = 5;
  localparam int INT1_EC_OUTPUT_BIT = 4;
  localparam int INT1_PIN_THREE_BIT = 3;
  localparam int INT1_SERIAL_BUS1_BIT = 2;
  localparam int INT1_MAILBOX_BIT = 1;
  localparam int INT1_ANY_WAKE_BIT = 0;
  // Bits software may clear by writing one: 6..2 and 0
  localparam logic [7:0] INT1_W1C_BITS = 8'h7D;

  // Wake group 1 bit positions
  localparam int WAKE1_PM_CTL_BIT = 7;
  localparam int WAKE1_PM_EN_BIT = 6;
  localparam int WAKE1_PM_STS_BIT = 5;
  localparam int WAKE1_SB1_BIT = 4;
  localparam int WAKE1_SB2_BIT = 3;
  localparam int WAKE1_IR_BIT = 2;
  localparam int WAKE1_EE1_BIT = 1;
  localparam int WAKE1_ALARM_BIT = 0;
  localparam logic [7:0] WAKE1_W1C_BITS = 8'hFE;
  localparam logic [7:0] WAKE1_ROC_BITS = 8'h01;

  // Edge detector lanes
  localparam int EDGE_W = 4;
  localparam int EDGE_OUT_FULL = 0;
  localparam int EDGE_IR = 1;
  localparam int EDGE_EE1 = 2;
  localparam int EDGE_ALARM = 3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } miwa_bus_req_t;

  typedef struct packed {
    logic kbd_host_write;
    logic kbd_mcu_read;
    logic ec_cmd_write;
    logic ec_data_write;
    logic mbox0_host_write;
    logic mbox0_read;
  } miwa_host_evt_t;

  typedef struct packed {
    logic pm_control_written;
    logic pm_enable_written;
    logic pm_status_written;
    logic sb1_wake_event;
    logic sb2_wake_event;
    logic secondary_supply_active;
    logic infrared_receive_in;
    logic either_edge_wake_1;
    logic clock_alarm_wake;
  } miwa_wake_src_t;

  typedef struct packed {
    logic [DATA_W-1:0] int0_enable_mask;
    logic [DATA_W-1:0] int1_enable_mask;
    logic [DATA_W-1:0] rdata;
    logic ext_irq0;
    logic ext_irq1;
    logic wake_irq;
  } miwa_core_state_t;

endpackage

// File: hw/miwa_flag_bank.sv
`timescale 1ns/100ps
module miwa_flag_bank #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] flags
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } miwa_flag_state_t;

  miwa_flag_state_t state_reg;
  miwa_flag_state_t state_next;

  // Set is applied after clear so an event in the clearing cycle survives
  always_comb begin
    state_next = state_reg;
    state_next.flags = (state_reg.flags & ~clr) | set;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '{flags: RESET_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags = state_reg.flags;
endmodule

// File: hw/miwa_edge_detect.sv
`timescale 1ns/100ps
module miwa_edge_detect #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic primed;
  } miwa_edge_state_t;

  miwa_edge_state_t state_reg;
  miwa_edge_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.prev = level;
    state_next.primed = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // No edges before the first sample, so a pin already high at reset is not an event
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      assign rise[i] = state_reg.primed & level[i] & ~state_reg.prev[i];
      assign fall[i] = state_reg.primed & ~level[i] & state_reg.prev[i];
    end
  endgenerate
endmodule

// File: hw/miwa_int_wake.sv
// What this block does
// - Serial bus 2 interrupt active makes interrupt-0 bit 3 read one.
// - Interrupt-0 mask: zero enables the same-position source, one masks it.
// - Interrupt-0 bits 7..0: ports D, C, B, A, bus 2, wake 4, 2, 3.
// - A masked source still reads set but drives no interrupt line, except pending wake, which still drives interrupt 1.
// - Both mask registers read/write and reset to 0x00, all enabled.
// - Enabled interrupt-1 bits are ORed onto external interrupt 1.
// - Interrupt-1 bits 0 and 2..6 clear on write-one; 7 and 1 read-only.
// - Keyboard input full sets on host write, clears on controller read.
// - Embedded-controller input flag sets on host command or data write.
// - Embedded-controller output flag sets when output-full status clears.
// - Interrupt-1 bit 2 reads one while serial bus 1 requests.
// - Mailbox flag sets on host mailbox 0 write, clears on its read.
// - Interrupt-1 mask: zero enables, one masks; same order as flags.
// - Any enabled wake input drives external interrupt 1 and wake line.
// - Wake register reads latched status; bits 7..1 clear by writing one.
// - Wake bits 7, 6, 5 set on power-management register writes.
// - Wake bit 4 on serial bus 1 event, bit 3 on bus 2.
// - Wake bit 2 sets on infrared falling edge with secondary supply on.
// - Wake bit 1 sets on either edge of either-edge wake 1 pin.
// - Wake bit 0 sets on alarm rising edge and clears on register read.
// - Interrupt-0 bits clear on write-one; enabled set bits drive interrupt 0.
`timescale 1ns/100ps
module miwa_int_wake (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire miwa_pkg::miwa_bus_req_t bus_req,
  output logic [miwa_pkg::DATA_W-1:0] mcu_rdata,
  input wire logic [miwa_pkg::DATA_W-1:0] int0_src,
  input wire miwa_pkg::miwa_host_evt_t host_evt,
  input wire logic key_matrix_event,
  input wire logic general_pin_three_irq,
  input wire logic serial_bus1_irq,
  input wire logic output_full_status,
  input wire miwa_pkg::miwa_wake_src_t wake_src,
  input wire logic [miwa_pkg::DATA_W-1:0] wake_group1_mask,
  input wire logic other_wake_pending,
  output logic mcu_ext_irq0,
  output logic mcu_ext_irq1,
  output logic mcu_wake_irq
);
  import miwa_pkg::*;

  miwa_core_state_t state_reg;
  miwa_core_state_t state_next;

  logic hit_int0_flag;
  logic hit_int0_enable_mask;
  logic hit_int1_flag;
  logic hit_int1_enable_mask;
  logic hit_wake1;
  logic [DATA_W-1:0] int0_flag;
  logic [DATA_W-1:0] int1_flag;
  logic [DATA_W-1:0] wake1_flag;
  logic [DATA_W-1:0] int0_set;
  logic [DATA_W-1:0] int0_clr;
  logic [DATA_W-1:0] int1_set;
  logic [DATA_W-1:0] int1_clr;
  logic [DATA_W-1:0] wake1_set;
  logic [DATA_W-1:0] wake1_clr;
  logic [EDGE_W-1:0] edge_level;
  logic [EDGE_W-1:0] edge_rise;
  logic [EDGE_W-1:0] edge_fall;
  logic wake_pending;

  assign hit_int0_flag = (bus_req.addr == INT0_FLAG_ADDR);
  assign hit_int0_enable_mask = (bus_req.addr == INT0_ENABLE_MASK_ADDR);
  assign hit_int1_flag = (bus_req.addr == INT1_FLAG_ADDR);
  assign hit_int1_enable_mask = (bus_req.addr == INT1_ENABLE_MASK_ADDR);
  assign hit_wake1 = (bus_req.addr == WAKE_FLAG_GROUP1_ADDR);

  always_comb begin
    edge_level = '0;
    edge_level[EDGE_OUT_FULL] = output_full_status;
    edge_level[EDGE_IR] = wake_src.infrared_receive_in;
    edge_level[EDGE_EE1] = wake_src.either_edge_wake_1;
    edge_level[EDGE_ALARM] = wake_src.clock_alarm_wake;
  end

  miwa_edge_detect #(
    .WIDTH(EDGE_W)
  ) u_edges (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .level(edge_level),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  // Interrupt-0 group: levels held by peripherals keep re-setting their bit,
  // so an active serial bus 2 request reads one even right after a clear.
  assign int0_set = int0_src;
  assign int0_clr = (bus_req.wr && hit_int0_flag) ? bus_req.wdata : '0;

  miwa_flag_bank #(
    .WIDTH(DATA_W),
    .RESET_VAL(INT0_FLAG_RST)
  ) u_int0_flags (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .set(int0_set),
    .clr(int0_clr),
    .flags(int0_flag)
  );

  // Wake group 1 sources
  always_comb begin
    wake1_set = '0;
    wake1_set[WAKE1_PM_CTL_BIT] = wake_src.pm_control_written;
    wake1_set[WAKE1_PM_EN_BIT] = wake_src.pm_enable_written;
    wake1_set[WAKE1_PM_STS_BIT] = wake_src.pm_status_written;
    wake1_set[WAKE1_SB1_BIT] = wake_src.sb1_wake_event;
    wake1_set[WAKE1_SB2_BIT] = wake_src.sb2_wake_event;
    // Infrared only wakes while the secondary supply is up
    wake1_set[WAKE1_IR_BIT] = wake_src.secondary_supply_active
                              & edge_fall[EDGE_IR];
    wake1_set[WAKE1_EE1_BIT] = edge_rise[EDGE_EE1] | edge_fall[EDGE_EE1];
    // Edge-triggered, so a read while the alarm still matches keeps it clear
    wake1_set[WAKE1_ALARM_BIT] = edge_rise[EDGE_ALARM];
  end

  always_comb begin
    wake1_clr = '0;
    if (bus_req.wr && hit_wake1) begin
      wake1_clr = bus_req.wdata & WAKE1_W1C_BITS;
    end
    if (bus_req.rd && hit_wake1) begin
      wake1_clr = wake1_clr | WAKE1_ROC_BITS;
    end
  end

  miwa_flag_bank #(
    .WIDTH(DATA_W),
    .RESET_VAL(WAKE_FLAG_GROUP1_RST)
  ) u_wake1_flags (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .set(wake1_set),
    .clr(wake1_clr),
    .flags(wake1_flag)
  );

  // The other wake groups live elsewhere and arrive already masked
  assign wake_pending = (|(wake1_flag & ~wake_group1_mask)) | other_wake_pending;

  // Interrupt-1 group sources
  always_comb begin
    int1_set = '0;
    int1_set[INT1_KBD_FULL_BIT] = host_evt.kbd_host_write;
    int1_set[INT1_KEY_MATRIX_BIT] = key_matrix_event;
    int1_set[INT1_EC_INPUT_BIT] = host_evt.ec_cmd_write | host_evt.ec_data_write;
    int1_set[INT1_EC_OUTPUT_BIT] = edge_fall[EDGE_OUT_FULL];
    int1_set[INT1_PIN_THREE_BIT] = general_pin_three_irq;
    int1_set[INT1_SERIAL_BUS1_BIT] = serial_bus1_irq;
    int1_set[INT1_MAILBOX_BIT] = host_evt.mbox0_host_write;
    int1_set[INT1_ANY_WAKE_BIT] = wake_pending;
  end

  always_comb begin
    int1_clr = '0;
    if (bus_req.wr && hit_int1_flag) begin
      int1_clr = bus_req.wdata & INT1_W1C_BITS;
    end
    // Read-only bits are cleared only by their own far-side events
    int1_clr[INT1_KBD_FULL_BIT] = host_evt.kbd_mcu_read;
    int1_clr[INT1_MAILBOX_BIT] = host_evt.mbox0_read;
  end

  miwa_flag_bank #(
    .WIDTH(DATA_W),
    .RESET_VAL(INT1_FLAG_RST)
  ) u_int1_flags (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .set(int1_set),
    .clr(int1_clr),
    .flags(int1_flag)
  );

  // Masks, read data and interrupt lines
  always_comb begin
    state_next = state_reg;
    if (bus_req.wr && hit_int0_enable_mask) begin
      state_next.int0_enable_mask = bus_req.wdata;
    end
    if (bus_req.wr && hit_int1_enable_mask) begin
      state_next.int1_enable_mask = bus_req.wdata;
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        INT0_FLAG_ADDR: begin
          state_next.rdata = int0_flag;
        end
        INT0_ENABLE_MASK_ADDR: begin
          state_next.rdata = state_reg.int0_enable_mask;
        end
        INT1_FLAG_ADDR: begin
          state_next.rdata = int1_flag;
        end
        INT1_ENABLE_MASK_ADDR: begin
          state_next.rdata = state_reg.int1_enable_mask;
        end
        WAKE_FLAG_GROUP1_ADDR: begin
          state_next.rdata = wake1_flag;
        end
        default: begin
          state_next.rdata = UNMAPPED_READ_VAL;
        end
      endcase
    end
    // Mask bit one blocks the line but leaves the flag visible; wake_pending still drives ext_irq1 whatever the mask
    state_next.ext_irq0 = |(int0_flag & ~state_reg.int0_enable_mask);
    state_next.ext_irq1 = (|(int1_flag & ~state_reg.int1_enable_mask))
                          | wake_pending;
    state_next.wake_irq = wake_pending;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '{int0_enable_mask: INT0_ENABLE_MASK_RST,
                     int1_enable_mask: INT1_ENABLE_MASK_RST,
                     rdata: UNMAPPED_READ_VAL,
                     ext_irq0: 1'b0,
                     ext_irq1: 1'b0,
                     wake_irq: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign mcu_rdata = state_reg.rdata;
  assign mcu_ext_irq0 = state_reg.ext_irq0;
  assign mcu_ext_irq1 = state_reg.ext_irq1;
  assign mcu_wake_irq = state_reg.wake_irq;
endmodule

// File: test/miwa_mcu_model.sv
`timescale 1ns/100ps
module miwa_mcu_model (
  input wire logic sys_clk,
  input wire logic [7:0] mcu_rdata,
  output miwa_pkg::miwa_bus_req_t bus_req
);
  import miwa_pkg::*;
  initial bus_req = '0;
  // Released lines flip so a stale address or data is never trusted
  task automatic idle();
    bus_req.wr = 1'b0;
    bus_req.rd = 1'b0;
    bus_req.addr = ~bus_req.addr;
    bus_req.wdata = ~bus_req.wdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req = {2'b10, a, d};
    @(negedge sys_clk);
    idle();
  endtask
  // Data is taken a cycle late, where it holds until the next read
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    bus_req = {2'b01, a, ~bus_req.wdata};
    @(negedge sys_clk);
    idle();
    @(negedge sys_clk);
    d = mcu_rdata;
  endtask
endmodule

// File: test/miwa_int_wake_assertions.sv
`timescale 1ns/100ps
module miwa_int_wake_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire miwa_pkg::miwa_bus_req_t bus_req,
  input wire logic [miwa_pkg::DATA_W-1:0] mcu_rdata,
  input wire logic [miwa_pkg::DATA_W-1:0] int0_src,
  input wire miwa_pkg::miwa_host_evt_t host_evt,
  input wire logic key_matrix_event,
  input wire logic general_pin_three_irq,
  input wire logic serial_bus1_irq,
  input wire logic output_full_status,
  input wire miwa_pkg::miwa_wake_src_t wake_src,
  input wire logic [miwa_pkg::DATA_W-1:0] wake_group1_mask,
  input wire logic other_wake_pending,
  input wire logic mcu_ext_irq0,
  input wire logic mcu_ext_irq1,
  input wire logic mcu_wake_irq
);
  import miwa_pkg::*;
  logic [7:0] m0_reg;
  logic [7:0] m1_reg;
  logic [7:0] s1;
  // Mask shadows tell which sources may reach a line
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      m0_reg <= 8'h00;
      m1_reg <= 8'h00;
    end else if (bus_req.wr) begin
      if (bus_req.addr == INT0_ENABLE_MASK_ADDR) m0_reg <= bus_req.wdata;
      if (bus_req.addr == INT1_ENABLE_MASK_ADDR) m1_reg <= bus_req.wdata;
    end
  end
  assign s1 = {host_evt.kbd_host_write, key_matrix_event,
    host_evt.ec_cmd_write | host_evt.ec_data_write, 1'b0, general_pin_three_irq,
    serial_bus1_irq, host_evt.mbox0_host_write, 1'b0};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence rd_at(logic [15:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  irq0_set_a: assert property (
    (|(int0_src & ~m0_reg)) && !bus_req.wr |-> ##2 mcu_ext_irq0) else $error("irq0 late");
  irq1_set_a: assert property (
    (|(s1 & ~m1_reg)) && !bus_req.wr |-> ##2 mcu_ext_irq1) else $error("irq1 late");
  full_drop_a: assert property (
    $fell(output_full_status) && !m1_reg[4] && !bus_req.wr ##1 !bus_req.wr
    |-> ##[1:2] mcu_ext_irq1) else $error("output full irq late");
  wake_set_a: assert property (
    wake_src.pm_control_written && !wake_group1_mask[7] && !m1_reg[0] && !bus_req.wr
    ##1 !wake_group1_mask[7] |-> ##1 mcu_wake_irq && mcu_ext_irq1) else $error("wake late");
  other_wake_a: assert property (
    other_wake_pending ##1 other_wake_pending |-> ##[0:1] mcu_wake_irq) else $error("wake off");
  irq0_quiet_a: assert property (
    (m0_reg == 8'hFF) [*3] |-> !mcu_ext_irq0) else $error("irq0 masked");
  wake_quiet_a: assert property (
    (wake_group1_mask == 8'hFF && !other_wake_pending) [*3] |-> !mcu_wake_irq)
    else $error("wake masked");
  mask0_read_a: assert property (
    rd_at(INT0_ENABLE_MASK_ADDR) |=> mcu_rdata == $past(m0_reg)) else $error("mask0 read");
  mask1_read_a: assert property (
    rd_at(INT1_ENABLE_MASK_ADDR) |=> mcu_rdata == $past(m1_reg)) else $error("mask1 read");
endmodule
bind miwa_int_wake miwa_int_wake_checker u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .mcu_rdata(mcu_rdata),
  .int0_src(int0_src), .host_evt(host_evt), .key_matrix_event(key_matrix_event),
  .general_pin_three_irq(general_pin_three_irq), .serial_bus1_irq(serial_bus1_irq),
  .output_full_status(output_full_status), .wake_src(wake_src),
  .wake_group1_mask(wake_group1_mask), .other_wake_pending(other_wake_pending),
  .mcu_ext_irq0(mcu_ext_irq0), .mcu_ext_irq1(mcu_ext_irq1), .mcu_wake_irq(mcu_wake_irq));

// File: test/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); \
  end \
end
module tb;
  import miwa_pkg::*;
  localparam logic [15:0] f0 = INT0_FLAG_ADDR;
  localparam logic [15:0] m0 = INT0_ENABLE_MASK_ADDR;
  localparam logic [15:0] f1 = INT1_FLAG_ADDR;
  localparam logic [15:0] m1 = INT1_ENABLE_MASK_ADDR;
  localparam logic [15:0] wk = WAKE_FLAG_GROUP1_ADDR;
  logic sys_clk;
  logic rstn;
  miwa_bus_req_t bus_req;
  miwa_host_evt_t host_evt;
  miwa_wake_src_t wake_src;
  logic [7:0] mcu_rdata, int0_src, wake_group1_mask;
  logic key_matrix_event, general_pin_three_irq, serial_bus1_irq, output_full_status;
  logic other_wake_pending, mcu_ext_irq0, mcu_ext_irq1, mcu_wake_irq;
  logic [15:0] regs [5] = '{f0, m0, f1, m1, wk};
  int num_errors = 0;
  int n_tests = 0;
  miwa_int_wake DUT (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .mcu_rdata(mcu_rdata),
    .int0_src(int0_src), .host_evt(host_evt), .key_matrix_event(key_matrix_event),
    .general_pin_three_irq(general_pin_three_irq), .serial_bus1_irq(serial_bus1_irq),
    .output_full_status(output_full_status), .wake_src(wake_src),
    .wake_group1_mask(wake_group1_mask), .other_wake_pending(other_wake_pending),
    .mcu_ext_irq0(mcu_ext_irq0), .mcu_ext_irq1(mcu_ext_irq1), .mcu_wake_irq(mcu_wake_irq));
  miwa_mcu_model mcu (.sys_clk(sys_clk), .mcu_rdata(mcu_rdata), .bus_req(bus_req));
  task automatic results();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    mcu.rd(a, v);
    `CHK($sformatf("reg %h", a), e, v)
  endtask
  task automatic irq(input logic [2:0] e);
    `CHK("irq0 irq1 wake", e, {mcu_ext_irq0, mcu_ext_irq1, mcu_wake_irq})
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    results();
  end
  initial begin
    rstn = 1'b0;
    int0_src = 8'h00;
    host_evt = '0;
    {key_matrix_event, general_pin_three_irq, serial_bus1_irq} = 3'b000;
    output_full_status = 1'b1;
    wake_src = 9'h00C;
    wake_group1_mask = 8'h00;
    other_wake_pending = 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    foreach (regs[i]) rchk(regs[i], 8'h00);
    rchk(16'h7F04, UNMAPPED_READ_VAL);
    mcu.wr(m0, 8'hFF);
    mcu.wr(m1, 8'h5A);
    rchk(m0, 8'hFF);
    rchk(m1, 8'h5A);
    mcu.wr(m0, 8'h00);
    mcu.wr(m1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      int0_src = 8'(1 << i);
      cyc(1);
      int0_src = 8'h00;
      cyc(2);
      irq(3'b100);
      rchk(f0, 8'(1 << i));
      mcu.wr(f0, 8'(1 << i));
      cyc(2);
      irq(3'b000);
    end
    // A held bus 2 request must survive its own clear
    mcu.wr(m0, 8'h08);
    int0_src = 8'h08;
    cyc(3);
    irq(3'b000);
    mcu.wr(f0, 8'h08);
    rchk(f0, 8'h08);
    int0_src = 8'h00;
    mcu.wr(f0, 8'h08);
    mcu.wr(m0, 8'h00);
    host_evt = 6'b101010;
    {key_matrix_event, general_pin_three_irq, serial_bus1_irq} = 3'b111;
    output_full_status = 1'b0;
    cyc(1);
    host_evt = '0;
    {key_matrix_event, general_pin_three_irq} = 2'b00;
    cyc(2);
    irq(3'b010);
    rchk(f1, 8'hFE);
    mcu.wr(f1, 8'hFF);
    rchk(f1, 8'h86);
    serial_bus1_irq = 1'b0;
    mcu.wr(f1, 8'h04);
    host_evt = 6'b010000;
    cyc(1);
    host_evt = '0;
    rchk(f1, 8'h02);
    host_evt = 6'b000001;
    cyc(1);
    host_evt = '0;
    cyc(2);
    irq(3'b000);
    rchk(f1, 8'h00);
    fork
      mcu.wr(f1, 8'h20);
      begin
        cyc(1);
        host_evt = 6'b000100;
        cyc(1);
        host_evt = '0;
      end
    join
    rchk(f1, 8'h20);
    // Only the pending embedded-controller input bit is masked
    mcu.wr(m1, 8'h20);
    cyc(2);
    irq(3'b000);
    mcu.wr(m1, 8'h00);
    cyc(2);
    irq(3'b010);
    mcu.wr(f1, 8'h20);
    for (int i = 0; i < 5; i++) begin
      wake_src = 9'h00C | (9'h100 >> i);
      cyc(1);
      wake_src = 9'h00C;
      cyc(1);
    end
    wake_src = 9'h008;
    cyc(2);
    wake_src = 9'h00A;
    cyc(2);
    wake_src = 9'h00B;
    cyc(3);
    irq(3'b011);
    rchk(f1, 8'h01);
    mcu.wr(wk, 8'h01);
    rchk(wk, 8'hFF);
    rchk(wk, 8'hFE);
    mcu.wr(wk, 8'hFE);
    wake_src = 9'h007;
    cyc(2);
    wake_src = 9'h003;
    cyc(2);
    wake_src = 9'h001;
    cyc(2);
    rchk(wk, 8'h02);
    mcu.wr(wk, 8'h02);
    rchk(wk, 8'h00);
    mcu.wr(f1, 8'h01);
    cyc(2);
    irq(3'b000);
    wake_group1_mask = 8'hFF;
    wake_src = 9'h101;
    cyc(1);
    wake_src = 9'h001;
    cyc(3);
    irq(3'b000);
    rchk(wk, 8'h80);
    other_wake_pending = 1'b1;
    cyc(3);
    irq(3'b011);
    results();
  end
endmodule
